// *** rtl/dcsw_defs.svh ***
// constants for the drive control and status word block
// How it works
// R1 - parameter values travel as integers scaled by a factor from the conversion index
// R2 - two 16-bit process words: control/status first, reference/output frequency second
// R3 - control bits take native meanings only when profile setting selects native profile
// R4 - bits 01:00 pick one of four preset references
// R5 - bit 02 zero requests dc braking and stop
// R6 - bit 03 zero switches output off so motor coasts
// R7 - bit 04 zero ramps down with quick-stop ramp time
// R8 - bit 05 zero freezes output frequency; only speed-up/down inputs change it
// R9 - while frozen, ramp stop and start input are ignored; coast or brake still stop
// R10 - bit 06 zero ramps down with selected ramp; one permits start
// R11 - trip reset only on rising edge of bit 07
// R12 - bit 08 one selects jog frequency as output reference
// R13 - bit 09 selects ramp pair one or two
// R14 - bit 10 zero makes the whole control word ignored
// R15 - bit 11 drives relay only if relay source selects control word
// R16 - bit 12 drives digital output only if its source selects control word
// R17 - bits 14:13 choose setup, only in multi-setup mode
// R18 - bit 15 reverses only if reversing source is serial, or, or and
// R19 - per-function setting combines control bit with digital input
// R20 - status 00 ready; status 01 ready with active coast
// R21 - status 02 one when motor can be started
// R22 - status 03 shows trip until reset
// R23 - status 06 shows trip lock, cleared only by power cycle
// R24 - status 09 shows serial control accepted
// R25 - status 11 shows start signal or nonzero output frequency
// R26 - status 14 shows output current above limit
// R27 - status bits 04, 05, 12 always zero
`ifndef DCSW_DEFS_SVH
`define DCSW_DEFS_SVH

// ----------------------------------------
// bus register offsets
// ----------------------------------------
`define DCSW_ADDR_CTRL      4'h0
`define DCSW_ADDR_REF       4'h1
`define DCSW_ADDR_CFG       4'h2
`define DCSW_ADDR_STATUS    4'h3
`define DCSW_ADDR_OUTFREQ   4'h4
`define DCSW_ADDR_PARAM     4'h5
`define DCSW_ADDR_CONV      4'h6
`define DCSW_ADDR_SCALED    4'h7
`define DCSW_ADDR_ACTIONS   4'h8

// ----------------------------------------
// control word bit positions
// ----------------------------------------
`define DCSW_CW_PRESET_LO   0
`define DCSW_CW_PRESET_HI   1
`define DCSW_CW_DCBRAKE     2
`define DCSW_CW_COAST       3
`define DCSW_CW_QSTOP       4
`define DCSW_CW_FREEZE      5
`define DCSW_CW_START       6
`define DCSW_CW_RESET       7
`define DCSW_CW_JOG         8
`define DCSW_CW_RAMP        9
`define DCSW_CW_VALID       10
`define DCSW_CW_RELAY       11
`define DCSW_CW_DOUT        12
`define DCSW_CW_SETUP_LO    13
`define DCSW_CW_SETUP_HI    14
`define DCSW_CW_REVERSE     15

// ----------------------------------------
// status word bit positions
// ----------------------------------------
`define DCSW_SW_READY       0
`define DCSW_SW_DRVREADY    1
`define DCSW_SW_CANSTART    2
`define DCSW_SW_TRIP        3
`define DCSW_SW_TRIPLOCK    6
`define DCSW_SW_WARN        7
`define DCSW_SW_ATREF       8
`define DCSW_SW_SERIAL      9
`define DCSW_SW_INRANGE     10
`define DCSW_SW_RUNNING     11
`define DCSW_SW_VOLTWARN    13
`define DCSW_SW_CURLIM      14
`define DCSW_SW_THERMWARN   15

// ----------------------------------------
// configuration register fields
// ----------------------------------------
`define DCSW_CFG_PROFILE    0
`define DCSW_CFG_RELAYSRC   1
`define DCSW_CFG_DOUTSRC    2
`define DCSW_CFG_MULTISET   3
`define DCSW_CFG_REVSRC_LO  4
`define DCSW_CFG_BRKSRC_LO  6
`define DCSW_CFG_COASTSRC_LO 8
`define DCSW_CFG_STARTSRC_LO 10
`define DCSW_CFG_PRESETSRC_LO 12
`define DCSW_CFG_SETUPSRC_LO 14
`define DCSW_CFG_RESET      16'h0001
`define DCSW_PROFILE_NATIVE 1'b1

// ----------------------------------------
// reset values and misc
// ----------------------------------------
`define DCSW_CTRL_RESET     16'h0000
`define DCSW_ACCEPT_RESET   16'h04ff
`define DCSW_CONV_MIN       -5
`define DCSW_CONV_MAX       2

`endif

// *** rtl/dcsw_pkg.sv ***
// types for the drive control and status word block
package dcsw_pkg;
	// how a control bit combines with its digital input
	typedef enum logic [1:0] {
		DCSW_SRC_INPUT,
		DCSW_SRC_SERIAL,
		DCSW_SRC_OR,
		DCSW_SRC_AND
	} dcsw_src_type;

	// drive actions decoded from the control word
	typedef struct packed {
		logic [1:0] presetSel;
		logic       dcBrake;
		logic       coast;
		logic       quickStop;
		logic       freeze;
		logic       rampStop;
		logic       tripReset;
		logic       jog;
		logic       rampPair;
		logic       relayOn;
		logic       digOutOn;
		logic [1:0] setupSel;
		logic       reverse;
	} dcsw_action_type;

	// drive state reported back
	typedef struct packed {
		logic ready;
		logic coastActive;
		logic tripped;
		logic tripLocked;
		logic warning;
		logic atRef;
		logic localCtrl;
		logic inRange;
		logic startSignal;
		logic voltWarn;
		logic overCurrent;
		logic thermWarn;
	} dcsw_drive_type;

	// idle and busy states of the conversion unit
	typedef enum logic [1:0] {
		DCSW_SCALE_IDLE,
		DCSW_SCALE_BUSY
	} dcsw_scale_state_type;
endpackage : dcsw_pkg

// *** rtl/dcsw_scaler.sv ***
// parameter value scaling by power of ten conversion index
`timescale 1ns/1ps
`include "dcsw_defs.svh"

module dcsw_scaler #(
	parameter int WIDTH = 32
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic [WIDTH-1:0] rawValue,
	input  wire logic [3:0]       convIndex,
	output logic      [WIDTH-1:0] scaled,
	output logic                  busy
);
	// ----------------------------------------
	// iterative multiply or divide by ten
	// ----------------------------------------
	dcsw_pkg::dcsw_scale_state_type state_reg;
	logic signed [WIDTH-1:0] acc_reg;
	logic signed [3:0]       steps_reg;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg <= dcsw_pkg::DCSW_SCALE_IDLE;
			acc_reg   <= '0;
			steps_reg <= 4'h0;
			scaled    <= '0;
			busy      <= 1'b0;
		end else begin
			unique case (state_reg)
				dcsw_pkg::DCSW_SCALE_IDLE: begin
					if (start) begin
						state_reg <= dcsw_pkg::DCSW_SCALE_BUSY;
						acc_reg   <= rawValue;
						steps_reg <= convIndex;
						busy      <= 1'b1;
					end
				end
				dcsw_pkg::DCSW_SCALE_BUSY: begin
					if (steps_reg == 4'h0) begin
						scaled    <= acc_reg; // [R1]
						busy      <= 1'b0;
						state_reg <= dcsw_pkg::DCSW_SCALE_IDLE;
					end else if (steps_reg[3]) begin
						acc_reg   <= WIDTH'(acc_reg / 10); // [R1]
						steps_reg <= steps_reg + 4'sh1;
					end else begin
						acc_reg   <= WIDTH'(acc_reg * 10); // [R1]
						steps_reg <= steps_reg - 4'sh1;
					end
				end
			endcase
		end
	end
endmodule : dcsw_scaler

// *** rtl/dcsw_control_status.sv ***
// control word decoder and status word builder with avalon register port
`timescale 1ns/1ps
`include "dcsw_defs.svh"

module dcsw_control_status #(
	parameter int WIDTH = 16
) (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic [3:0]              avsAddress,
	input  wire logic                    avsRead,
	input  wire logic                    avsWrite,
	input  wire logic [31:0]             avsWritedata,
	input  wire logic [3:0]              avsByteenable,
	output logic      [31:0]             avsReaddata,
	output logic                         avsWaitrequest,
	output logic      [1:0]              avsResponse,
	input  wire logic                    dinDcBrake,
	input  wire logic                    dinCoast,
	input  wire logic                    dinStart,
	input  wire logic [1:0]              dinPreset,
	input  wire logic [1:0]              dinSetup,
	input  wire logic                    dinReverse,
	input  wire logic                    dinSpeedUp,
	input  wire logic                    dinSpeedDown,
	input  wire logic                    driveReady,
	input  wire logic                    driveTripped,
	input  wire logic                    driveTripLock,
	input  wire logic                    driveWarning,
	input  wire logic                    driveAtRef,
	input  wire logic                    driveLocalCtrl,
	input  wire logic                    driveInRange,
	input  wire logic                    driveVoltWarn,
	input  wire logic                    driveOverCurrent,
	input  wire logic                    driveThermWarn,
	input  wire logic [WIDTH-1:0]        driveOutFreq,
	output dcsw_pkg::dcsw_action_type    actions,
	output logic                         tripResetPulse,
	output logic                         relayOut,
	output logic                         digitalOut,
	output logic      [WIDTH-1:0]        referenceOut,
	output logic      [WIDTH-1:0]        firstProcessWord,
	output logic      [WIDTH-1:0]        secondProcessWord
);
	// ----------------------------------------
	// pin input synchronisers
	// ----------------------------------------
	localparam int NSYNC = 22;
	logic [NSYNC-1:0] pinRaw;
	logic [NSYNC-1:0] syncA_reg;
	logic [NSYNC-1:0] syncB_reg;

	assign pinRaw = {dinDcBrake, dinCoast, dinStart, dinPreset, dinSetup, dinReverse, dinSpeedUp, dinSpeedDown,
		driveReady, driveTripped, driveTripLock, driveWarning, driveAtRef, driveLocalCtrl, driveInRange,
		driveVoltWarn, driveOverCurrent, driveThermWarn, 2'b00};

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			syncA_reg <= '0;
			syncB_reg <= '0;
		end else begin
			syncA_reg <= pinRaw;
			syncB_reg <= syncA_reg;
		end
	end

	logic       sBrake, sCoast, sStart, sRev, sUp, sDown;
	logic [1:0] sPreset, sSetup;
	dcsw_pkg::dcsw_drive_type drv;

	assign {sBrake, sCoast, sStart, sPreset, sSetup, sRev, sUp, sDown} = syncB_reg[21:12];
	assign drv.ready       = syncB_reg[11];
	assign drv.tripped     = syncB_reg[10];
	assign drv.tripLocked  = syncB_reg[9];
	assign drv.warning     = syncB_reg[8];
	assign drv.atRef       = syncB_reg[7];
	assign drv.localCtrl   = syncB_reg[6];
	assign drv.inRange     = syncB_reg[5];
	assign drv.voltWarn    = syncB_reg[4];
	assign drv.overCurrent = syncB_reg[3];
	assign drv.thermWarn   = syncB_reg[2];
	assign drv.coastActive = sCoast;
	assign drv.startSignal = sStart;

	// ----------------------------------------
	// software registers
	// ----------------------------------------
	logic [15:0] ctrl_reg;
	logic [15:0] ref_reg;
	logic [15:0] cfg_reg;
	logic [31:0] param_reg;
	logic [3:0]  conv_reg;
	logic        scaleStart_reg;
	logic        ctrlNew_reg;

	// byte-lane merge for a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] be);
		merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// combine a control bit with its digital input per source setting
	function automatic logic gate(input logic [1:0] src, input logic bus, input logic pin);
		unique case (dcsw_pkg::dcsw_src_type'(src))
			dcsw_pkg::DCSW_SRC_INPUT:  gate = pin;
			dcsw_pkg::DCSW_SRC_SERIAL: gate = bus;
			dcsw_pkg::DCSW_SRC_OR:     gate = bus | pin;
			dcsw_pkg::DCSW_SRC_AND:    gate = bus & pin;
		endcase
	endfunction : gate

	logic wrStrobe;
	assign wrStrobe = avsWrite & ~avsWaitrequest;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctrl_reg       <= `DCSW_CTRL_RESET;
			ref_reg        <= 16'h0000;
			cfg_reg        <= `DCSW_CFG_RESET;
			param_reg      <= 32'h0000_0000;
			conv_reg       <= 4'h0;
			scaleStart_reg <= 1'b0;
			ctrlNew_reg    <= 1'b0;
		end else begin
			scaleStart_reg <= 1'b0;
			ctrlNew_reg    <= 1'b0;
			if (wrStrobe) begin
				unique case (avsAddress)
					`DCSW_ADDR_CTRL: begin
						ctrl_reg    <= merge16(ctrl_reg, avsWritedata, avsByteenable); // [R2]
						ctrlNew_reg <= 1'b1;
					end
					`DCSW_ADDR_REF:   ref_reg <= merge16(ref_reg, avsWritedata, avsByteenable); // [R2]
					`DCSW_ADDR_CFG:   cfg_reg <= merge16(cfg_reg, avsWritedata, avsByteenable);
					`DCSW_ADDR_PARAM: param_reg <= avsWritedata;
					`DCSW_ADDR_CONV: begin
						conv_reg       <= avsWritedata[3:0];
						scaleStart_reg <= 1'b1; // [R1]
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// parameter scaling
	// ----------------------------------------
	logic [31:0] scaledValue;
	logic        scaleBusy;

	dcsw_scaler #(
		.WIDTH(32)
	) u_scaler (
		.clock    (clock),
		.rst      (rst),
		.start    (scaleStart_reg),
		.rawValue (param_reg),
		.convIndex(conv_reg),
		.scaled   (scaledValue),
		.busy     (scaleBusy)
	);

	// ----------------------------------------
	// control word decode
	// ----------------------------------------
	logic native, valid, frozen, prevReset_reg;
	assign native = cfg_reg[`DCSW_CFG_PROFILE] == `DCSW_PROFILE_NATIVE; // [R3]
	assign valid  = native & ctrl_reg[`DCSW_CW_VALID]; // [R14]

	// latched accepted word; invalid words leave the last one in force
	logic [15:0] active_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			active_reg <= `DCSW_ACCEPT_RESET;
		end else if (ctrlNew_reg && valid) begin
			active_reg <= ctrl_reg; // [R14]
		end
	end

	assign frozen = ~active_reg[`DCSW_CW_FREEZE]; // [R8]

	dcsw_pkg::dcsw_action_type actNext;
	logic [1:0] revSrc;
	assign revSrc = cfg_reg[`DCSW_CFG_REVSRC_LO +: 2];

	always_comb begin
		actNext = '0;
		actNext.presetSel = {gate(cfg_reg[`DCSW_CFG_PRESETSRC_LO +: 2], active_reg[`DCSW_CW_PRESET_HI], sPreset[1]),
			gate(cfg_reg[`DCSW_CFG_PRESETSRC_LO +: 2], active_reg[`DCSW_CW_PRESET_LO], sPreset[0])}; // [R4] [R19]
		actNext.dcBrake   = ~gate(cfg_reg[`DCSW_CFG_BRKSRC_LO +: 2], active_reg[`DCSW_CW_DCBRAKE], ~sBrake); // [R5] [R19]
		actNext.coast     = ~gate(cfg_reg[`DCSW_CFG_COASTSRC_LO +: 2], active_reg[`DCSW_CW_COAST], ~sCoast); // [R6] [R19]
		actNext.quickStop = ~active_reg[`DCSW_CW_QSTOP]; // [R7]
		actNext.freeze    = frozen; // [R8]
		// ramp stop ignored while frozen
		actNext.rampStop  = ~frozen & ~gate(cfg_reg[`DCSW_CFG_STARTSRC_LO +: 2], active_reg[`DCSW_CW_START], sStart); // [R9] [R10]
		actNext.jog       = active_reg[`DCSW_CW_JOG]; // [R12]
		actNext.rampPair  = active_reg[`DCSW_CW_RAMP]; // [R13]
		actNext.relayOn   = cfg_reg[`DCSW_CFG_RELAYSRC] & active_reg[`DCSW_CW_RELAY]; // [R15]
		actNext.digOutOn  = cfg_reg[`DCSW_CFG_DOUTSRC] & active_reg[`DCSW_CW_DOUT]; // [R16]
		actNext.setupSel  = cfg_reg[`DCSW_CFG_MULTISET] ?
			{gate(cfg_reg[`DCSW_CFG_SETUPSRC_LO +: 2], active_reg[`DCSW_CW_SETUP_HI], sSetup[1]),
			gate(cfg_reg[`DCSW_CFG_SETUPSRC_LO +: 2], active_reg[`DCSW_CW_SETUP_LO], sSetup[0])} : 2'b00; // [R17]
		actNext.reverse   = (revSrc == 2'b00) ? sRev : gate(revSrc, active_reg[`DCSW_CW_REVERSE], sRev); // [R18]
		actNext.tripReset = active_reg[`DCSW_CW_RESET] & ~prevReset_reg; // [R11]
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			// reset word has bit 07 set; no false edge after reset
			prevReset_reg  <= 1'b1;
			actions        <= '0;
			tripResetPulse <= 1'b0;
			relayOut       <= 1'b0;
			digitalOut     <= 1'b0;
			referenceOut   <= '0;
		end else begin
			prevReset_reg  <= active_reg[`DCSW_CW_RESET]; // [R11]
			actions        <= actNext;
			tripResetPulse <= actNext.tripReset; // [R11]
			relayOut       <= actNext.relayOn; // [R15]
			digitalOut     <= actNext.digOutOn; // [R16]
			referenceOut   <= WIDTH'(ref_reg); // [R2]
		end
	end

	// ----------------------------------------
	// status word
	// ----------------------------------------
	logic [15:0] statusNext;
	logic        running;
	assign running = ~actNext.rampStop | (driveOutFreq != '0);

	always_comb begin
		statusNext = 16'h0000; // [R27]
		statusNext[`DCSW_SW_READY]     = drv.ready; // [R20]
		statusNext[`DCSW_SW_DRVREADY]  = drv.ready & actNext.coast; // [R20]
		statusNext[`DCSW_SW_CANSTART]  = ~actNext.coast & ~actNext.dcBrake & ~drv.tripped; // [R21]
		statusNext[`DCSW_SW_TRIP]      = drv.tripped; // [R22]
		statusNext[`DCSW_SW_TRIPLOCK]  = drv.tripLocked; // [R23]
		statusNext[`DCSW_SW_WARN]      = drv.warning;
		statusNext[`DCSW_SW_ATREF]     = drv.atRef;
		statusNext[`DCSW_SW_SERIAL]    = ~drv.localCtrl; // [R24]
		statusNext[`DCSW_SW_INRANGE]   = drv.inRange;
		statusNext[`DCSW_SW_RUNNING]   = running; // [R25]
		statusNext[`DCSW_SW_VOLTWARN]  = drv.voltWarn;
		statusNext[`DCSW_SW_CURLIM]    = drv.overCurrent; // [R26]
		statusNext[`DCSW_SW_THERMWARN] = drv.thermWarn;
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			firstProcessWord  <= '0;
			secondProcessWord <= '0;
		end else begin
			firstProcessWord  <= WIDTH'(statusNext); // [R2]
			secondProcessWord <= driveOutFreq; // [R2]
		end
	end

	// ----------------------------------------
	// avalon read path, one wait cycle
	// ----------------------------------------
	logic pending_reg;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pending_reg    <= 1'b0;
			avsWaitrequest <= 1'b1;
			avsReaddata    <= 32'h0000_0000;
			avsResponse    <= 2'b00;
		end else begin
			avsWaitrequest <= 1'b1;
			pending_reg    <= 1'b0;
			if ((avsRead | avsWrite) && !pending_reg && avsWaitrequest) begin
				pending_reg    <= 1'b1;
				avsWaitrequest <= 1'b0;
				avsResponse    <= (avsAddress > `DCSW_ADDR_ACTIONS) ? 2'b10 : 2'b00;
				unique case (avsAddress)
					`DCSW_ADDR_CTRL:    avsReaddata <= {16'h0000, ctrl_reg};
					`DCSW_ADDR_REF:     avsReaddata <= {16'h0000, ref_reg};
					`DCSW_ADDR_CFG:     avsReaddata <= {16'h0000, cfg_reg};
					`DCSW_ADDR_STATUS:  avsReaddata <= {16'h0000, statusNext};
					`DCSW_ADDR_OUTFREQ: avsReaddata <= 32'(driveOutFreq);
					`DCSW_ADDR_PARAM:   avsReaddata <= param_reg;
					`DCSW_ADDR_CONV:    avsReaddata <= {27'h0, scaleBusy, conv_reg};
					`DCSW_ADDR_SCALED:  avsReaddata <= scaledValue;
					`DCSW_ADDR_ACTIONS: avsReaddata <= {16'h0000, active_reg};
					default:            avsReaddata <= 32'h0000_0000;
				endcase
			end
		end
	end
endmodule : dcsw_control_status

// *** bench/dcsw_control_status_asserts.sv ***
// port assertions for the control and status word block
`timescale 1ns/1ps
module dcsw_control_status_asserts #(
	parameter int WIDTH = 16
) (
	input wire logic                      clock,
	input wire logic                      rst,
	input wire logic [3:0]                avsAddress,
	input wire logic                      avsRead,
	input wire logic                      avsWrite,
	input wire logic [31:0]               avsReaddata,
	input wire logic                      avsWaitrequest,
	input wire logic [1:0]                avsResponse,
	input wire logic                      driveReady,
	input wire logic                      driveTripped,
	input wire logic                      driveTripLock,
	input wire logic                      driveLocalCtrl,
	input wire logic                      driveOverCurrent,
	input wire logic [WIDTH-1:0]          driveOutFreq,
	input wire dcsw_pkg::dcsw_action_type actions,
	input wire logic                      tripResetPulse,
	input wire logic [WIDTH-1:0]          firstProcessWord,
	input wire logic [WIDTH-1:0]          secondProcessWord
);
	default clocking dcb @(posedge clock);
	endclocking
	default disable iff (rst);
	AST_ANSWER: assert property ((avsRead || avsWrite) && avsWaitrequest |-> ##[1:2] !avsWaitrequest)
		else $error("bus request not answered");
	AST_ONE_CYCLE: assert property (!avsWaitrequest |=> avsWaitrequest)
		else $error("answer held too long");
	AST_UNMAPPED: assert property (!avsWaitrequest && avsRead && avsAddress > 4'h8 |-> avsResponse == 2'b10 && avsReaddata == 32'h0)
		else $error("unmapped read not refused");
	AST_TRIP: assert property (driveTripped [*5] |-> firstProcessWord[3])
		else $error("trip not shown");
	AST_TRIPLOCK: assert property (driveTripLock [*5] |-> firstProcessWord[6])
		else $error("trip lock not shown");
	AST_SERIAL: assert property (driveLocalCtrl [*5] |-> !firstProcessWord[9])
		else $error("serial control shown in local mode");
	AST_CURLIM: assert property (!driveOverCurrent [*5] |-> !firstProcessWord[14])
		else $error("current limit shown without cause");
	AST_READY: assert property (!driveReady [*5] |-> firstProcessWord[1:0] == 2'b00)
		else $error("ready shown while not ready");
	AST_UNUSED: assert property (firstProcessWord[5:4] == 2'b00 && !firstProcessWord[12])
		else $error("unused status bit set");
	AST_SECOND: assert property (!$past(rst) |-> secondProcessWord == $past(driveOutFreq))
		else $error("second word not output frequency");
	AST_PULSE: assert property (tripResetPulse |-> actions.tripReset ##1 !tripResetPulse)
		else $error("reset pulse wrong");
	AST_FREEZE: assert property (actions.freeze |-> !actions.rampStop)
		else $error("ramp stop while frozen");
endmodule : dcsw_control_status_asserts

bind dcsw_control_status dcsw_control_status_asserts #(.WIDTH(WIDTH)) dcsw_control_status_asserts_inst (
	.clock, .rst, .avsAddress, .avsRead, .avsWrite, .avsReaddata, .avsWaitrequest, .avsResponse,
	.driveReady, .driveTripped, .driveTripLock, .driveLocalCtrl, .driveOverCurrent, .driveOutFreq,
	.actions, .tripResetPulse, .firstProcessWord, .secondProcessWord
);

// *** bench/dcsw_bus_master.sv ***
// bus master model standing in for the serial master
`timescale 1ns/1ps
module dcsw_bus_master (
	input  wire logic        clock,
	input  wire logic        avsWaitrequest,
	input  wire logic [31:0] avsReaddata,
	output logic      [3:0]  avsAddress,
	output logic             avsRead,
	output logic             avsWrite,
	output logic      [31:0] avsWritedata,
	output logic      [3:0]  avsByteenable
);
	initial begin
		avsAddress = 4'h0;
		avsRead = 1'b0;
		avsWrite = 1'b0;
		avsWritedata = 32'h0;
		avsByteenable = 4'h0;
	end
	// one transfer held until waitrequest drops
	task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic late);
		int n;
		n = 0;
		@(posedge clock);
		avsAddress <= a;
		avsWritedata <= d;
		avsByteenable <= 4'hf;
		avsRead <= !wr;
		avsWrite <= wr;
		do begin
			@(posedge clock);
			n++;
		end while (avsWaitrequest !== 1'b0 && n < 64);
		late = (avsWaitrequest !== 1'b0);
		// released lines show the inverse, not a stale copy
		avsRead <= 1'b0;
		avsWrite <= 1'b0;
		avsAddress <= ~a;
		avsWritedata <= ~d;
		avsByteenable <= 4'h0;
	endtask : xfer
endmodule : dcsw_bus_master

// *** bench/tb_drive_control_status_word.sv ***
// self-checking bench for the control and status word block
`timescale 1ns/1ps
`include "dcsw_defs.svh"
module tb_drive_control_status_word;
	logic                      clock;
	logic                      rst;
	logic [3:0]                avsAddress;
	logic                      avsRead;
	logic                      avsWrite;
	logic [31:0]               avsWritedata;
	logic [3:0]                avsByteenable;
	logic [31:0]               avsReaddata;
	logic                      avsWaitrequest;
	logic [1:0]                avsResponse;
	logic [9:0]                din;
	logic [9:0]                st;
	logic [15:0]               freq;
	dcsw_pkg::dcsw_action_type actions;
	logic                      tripResetPulse;
	logic                      relayOut;
	logic                      digitalOut;
	logic [15:0]               referenceOut;
	logic [15:0]               firstProcessWord;
	logic [15:0]               secondProcessWord;
	logic [33:0]               expQ[$];
	int                        fail_count;
	int                        n_tests;
	int                        pulses;

	dcsw_control_status #(.WIDTH(16)) dcsw_control_status_inst (
		.clock, .rst, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable, .avsReaddata,
		.avsWaitrequest, .avsResponse, .dinDcBrake(din[0]), .dinCoast(din[1]), .dinStart(din[2]),
		.dinPreset(din[4:3]), .dinSetup(din[6:5]), .dinReverse(din[7]), .dinSpeedUp(din[8]),
		.dinSpeedDown(din[9]), .driveReady(st[0]), .driveTripped(st[1]), .driveTripLock(st[2]),
		.driveWarning(st[3]), .driveAtRef(st[4]), .driveLocalCtrl(st[5]), .driveInRange(st[6]),
		.driveVoltWarn(st[7]), .driveOverCurrent(st[8]), .driveThermWarn(st[9]), .driveOutFreq(freq),
		.actions, .tripResetPulse, .relayOut, .digitalOut, .referenceOut, .firstProcessWord, .secondProcessWord
	);
	dcsw_bus_master dcsw_bus_master_inst (
		.clock, .avsWaitrequest, .avsReaddata, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsByteenable
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic late;
		dcsw_bus_master_inst.xfer(wr, a, d, late);
		if (late) begin
			fail_count++;
			$display("[ERR] bus expected answer seen none");
			end_of_test();
		end
	endtask : bus

	task automatic rd(input logic [3:0] a, input logic [33:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic settle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : settle

	// expected actions, reset-request bit left out
	function automatic logic [14:0] act(input logic [15:0] w);
		return {w[1:0], ~w[2], ~w[3], ~w[4], ~w[5], ~w[6] & w[5], 1'b0, w[8], w[9], w[11], w[12], w[14:13], w[15]};
	endfunction : act

	function automatic logic [15:0] stw(input logic [15:0] w);
		return {st[9:7], 1'b0, 1'b1, st[6], ~st[5], st[4:2], 2'b00, st[1], w[3] & w[2] & ~st[1], st[0] & ~w[3], st[0]};
	endfunction : stw

	function automatic logic [31:0] scl(input logic [31:0] v, input int x);
		for (int k = 0; k < 8; k++)
			if (k < x) v = v * 10;
			else if (k < -x) v = v / 10;
		return v;
	endfunction : scl

	// read answers checked against the oldest note
	always @(posedge clock) begin
		if (!rst && avsRead && avsWaitrequest === 1'b0 && expQ.size() > 0)
			chk("read", expQ.pop_front(), {avsResponse, avsReaddata});
	end

	always @(posedge clock) begin
		if (tripResetPulse === 1'b1)
			pulses++;
	end

	initial begin
		logic [15:0] w;
		logic [31:0] v;
		fail_count = 0;
		n_tests = 0;
		pulses = 0;
		v = $urandom(47);
		rst = 1'b1;
		din = 10'h0;
		st = 10'h0;
		freq = 16'h0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		settle(3);
		// input-only sources, idle pins: only ramp stop active
		chk("reset actions", 34'h100, {19'h0, actions & 15'h7f7f});
		rd(`DCSW_ADDR_CFG, 34'h1);
		rd(`DCSW_ADDR_ACTIONS, 34'h4ff);
		rd(4'h9, {2'b10, 32'h0});
		bus(1'b1, 4'hc, 32'hffff);
		bus(1'b1, `DCSW_ADDR_CFG, 32'h555f);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			st <= 10'($urandom());
			din <= 10'($urandom());
			freq <= 16'($urandom()) | 16'h1;
			w = 16'($urandom()) | 16'h0400;
			bus(1'b1, `DCSW_ADDR_REF, {16'h0, ~w});
			bus(1'b1, `DCSW_ADDR_CTRL, {16'h0, w});
			settle(6);
			chk("actions", {19'h0, act(w)}, {19'h0, actions & 15'h7f7f});
			chk("outputs", {32'h0, w[12:11]}, {32'h0, digitalOut, relayOut});
			chk("reference", {18'h0, ~w}, {18'h0, referenceOut});
			chk("status", {18'h0, stw(w)}, {18'h0, firstProcessWord});
			rd(`DCSW_ADDR_STATUS, {18'h0, stw(w)});
			rd(`DCSW_ADDR_OUTFREQ, {18'h0, freq});
		end
		bus(1'b1, `DCSW_ADDR_CTRL, {16'h0, w ^ 16'h0c00});
		settle(4);
		rd(`DCSW_ADDR_ACTIONS, {18'h0, w});
		bus(1'b1, `DCSW_ADDR_CFG, 32'h555e);
		bus(1'b1, `DCSW_ADDR_CTRL, {16'h0, w ^ 16'h0800});
		settle(4);
		chk("ignored", {19'h0, act(w)}, {19'h0, actions & 15'h7f7f});
		bus(1'b1, `DCSW_ADDR_CFG, 32'h555f);
		bus(1'b1, `DCSW_ADDR_CTRL, 32'h047f);
		settle(4);
		pulses = 0;
		bus(1'b1, `DCSW_ADDR_CTRL, 32'h04ff);
		bus(1'b1, `DCSW_ADDR_CTRL, 32'h04ff);
		settle(4);
		chk("reset pulses", 34'h1, 34'(pulses));
		din[7] <= 1'b0;
		bus(1'b1, `DCSW_ADDR_CFG, 32'h5541);
		bus(1'b1, `DCSW_ADDR_CTRL, 32'hfcff);
		settle(6);
		chk("gated", {29'h0, din[7], 4'h0}, {29'h0, actions.reverse, digitalOut, relayOut, actions.setupSel});
		for (int x = -5; x <= 2; x++) begin
			v = $urandom() % 100000;
			bus(1'b1, `DCSW_ADDR_PARAM, v);
			bus(1'b1, `DCSW_ADDR_CONV, 32'(x) & 32'hf);
			settle(8);
			rd(`DCSW_ADDR_SCALED, {2'b00, scl(v, x)});
		end
		settle(2);
		end_of_test();
	end
endmodule : tb_drive_control_status_word
